// file: queue_flag_host.sv
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module queue_flag_host import mq_flag_pkg::*; (
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	input  wire logic [AXI_AW-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	input  wire logic [AXI_AW-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	input  wire logic              CHAIN_TOKEN_IN,
	output logic                   CHAIN_TOKEN_OUT,
	flag_link_if.ctrl              LNK
);
	logic [31:0]       ctrl_q, ctrl_d;
	logic [31:0]       strap_q, strap_d;
	mrst_e             mr_q, mr_d;
	logic [3:0]        mcnt_q, mcnt_d;
	logic              refus_q, refus_d;
	logic              aw_q, aw_d, w_q, w_d;
	logic [AXI_AW-1:0] awa_q, awa_d;
	logic [31:0]       wd_q, wd_d;
	logic [3:0]        ws_q, ws_d;
	logic              bv_q, bv_d, rv_q, rv_d;
	logic [1:0]        br_q, br_d, rr_q, rr_d;
	logic [31:0]       rd_q, rd_d;
	logic [7:0]        wa_q, wa_d, ra_q, ra_d;
	logic              wsel_q, wsel_d, rsel_q, rsel_d, stb_q, stb_d;
	logic [31:0]       wmask, status;
	logic              do_wr, single, prog_done;

	assign single    = strap_q[C_SINGLE];
	assign prog_done = !LNK.serial_program_done;
	assign wmask     = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
	assign do_wr     = aw_q && w_q && !bv_q;
	assign status    = {8'h0, LNK.almost_full_flag_bus, 7'h0, LNK.almost_full_bus_sync,
		5'h0, refus_q, prog_done, (mr_q != C_IDLE)};

	// bus slave, reset sequencer and selection pulses
	always_comb begin
		ctrl_d  = ctrl_q;
		strap_d = strap_q;
		mr_d    = mr_q;
		mcnt_d  = mcnt_q;
		refus_d = refus_q;
		aw_d    = aw_q;
		w_d     = w_q;
		awa_d   = awa_q;
		wd_d    = wd_q;
		ws_d    = ws_q;
		bv_d    = bv_q && !S_AXI_BREADY;
		br_d    = br_q;
		rv_d    = rv_q && !S_AXI_RREADY;
		rr_d    = rr_q;
		rd_d    = rd_q;
		wa_d    = wa_q;
		ra_d    = ra_q;
		wsel_d  = 1'b0;
		rsel_d  = 1'b0;
		stb_d   = 1'b0;
		// address and data are caught independently, in either order
		if (S_AXI_AWVALID && !aw_q) begin
			aw_d  = 1'b1;
			awa_d = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !w_q) begin
			w_d  = 1'b1;
			wd_d = S_AXI_WDATA;
			ws_d = S_AXI_WSTRB;
		end
		// reset sequence: high one cycle, low a few, then high
		case (mr_q)
			C_PRE: mr_d = C_LOW; // [R15]
			C_LOW: begin
				mcnt_d = mcnt_q + 4'h1;
				if (mcnt_q == RST_LOW_CYCLES) begin
					mr_d = C_IDLE; // [R15]
				end
			end
			default: mr_d = C_IDLE;
		endcase
		if (do_wr) begin
			aw_d = 1'b0;
			w_d  = 1'b0;
			bv_d = 1'b1;
			br_d = RESP_OK;
			case (awa_q)
				CTRL_OFS: begin
					ctrl_d = (ctrl_q & ~wmask) | (wd_q & wmask);
					ctrl_d[C_GO] = 1'b0;
					// straps freeze at reset start so they never move in use
					if (wd_q[C_GO] && ws_q[0] && mr_q == C_IDLE) begin
						strap_d = ctrl_d; // [R10]
						mr_d    = C_PRE;
						mcnt_d  = 4'h0;
					end
				end
				SEL_OFS: if (mr_q == C_IDLE) begin
					wa_d   = wd_q[7:0];
					ra_d   = wd_q[7:0];
					wsel_d = wd_q[S_WSEL];
					rsel_d = wd_q[S_RSEL];
					// strobe only in direct mode after programming
					stb_d  = wd_q[S_STROBE] && !strap_q[C_POLLED] && prog_done; // [R2] [R3]
					if (wd_q[S_STROBE] && !stb_d) begin
						refus_d = 1'b1;
					end
				end
				STAT_OFS: if (wd_q[ST_REFUS] && ws_q[0]) begin
					refus_d = 1'b0;
				end
				default: br_d = RESP_DEC;
			endcase
		end
		// a refusal in the same cycle as its clear is kept
		if (do_wr && awa_q == SEL_OFS && mr_q == C_IDLE && wd_q[S_STROBE]
			&& (strap_q[C_POLLED] || !prog_done)) begin
			refus_d = 1'b1;
		end
		if (S_AXI_ARVALID && !rv_q) begin
			rv_d = 1'b1;
			rr_d = RESP_OK;
			case (S_AXI_ARADDR)
				CTRL_OFS: rd_d = ctrl_q;
				SEL_OFS:  rd_d = {24'h0, wa_q};
				STAT_OFS: rd_d = status;
				default: begin
					rd_d = 32'h0;
					rr_d = RESP_DEC;
				end
			endcase
		end
	end

	// registers only
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl_q  <= CTRL_RST;
			strap_q <= CTRL_RST;
			mr_q    <= C_IDLE;
			mcnt_q  <= 4'h0;
			refus_q <= 1'b0;
			aw_q    <= 1'b0;
			w_q     <= 1'b0;
			awa_q   <= 4'h0;
			wd_q    <= 32'h0;
			ws_q    <= 4'h0;
			bv_q    <= 1'b0;
			br_q    <= RESP_OK;
			rv_q    <= 1'b0;
			rr_q    <= RESP_OK;
			rd_q    <= 32'h0;
			wa_q    <= 8'h0;
			ra_q    <= 8'h0;
			wsel_q  <= 1'b0;
			rsel_q  <= 1'b0;
			stb_q   <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			strap_q <= strap_d;
			mr_q    <= mr_d;
			mcnt_q  <= mcnt_d;
			refus_q <= refus_d;
			aw_q    <= aw_d;
			w_q     <= w_d;
			awa_q   <= awa_d;
			wd_q    <= wd_d;
			ws_q    <= ws_d;
			bv_q    <= bv_d;
			br_q    <= br_d;
			rv_q    <= rv_d;
			rr_q    <= rr_d;
			rd_q    <= rd_d;
			wa_q    <= wa_d;
			ra_q    <= ra_d;
			wsel_q  <= wsel_d;
			rsel_q  <= rsel_d;
			stb_q   <= stb_d;
		end
	end

	assign S_AXI_AWREADY = !aw_q;
	assign S_AXI_WREADY  = !w_q;
	assign S_AXI_BVALID  = bv_q;
	assign S_AXI_BRESP   = br_q;
	assign S_AXI_ARREADY = !rv_q;
	assign S_AXI_RVALID  = rv_q;
	assign S_AXI_RRESP   = rr_q;
	assign S_AXI_RDATA   = rd_q;

	// single device forces identity zero and master; chain takes ring token
	assign LNK.master_reset_n         = (mr_q != C_LOW); // [R15]
	assign LNK.flag_bus_mode          = strap_q[C_POLLED];
	assign LNK.master_select          = strap_q[C_MASTER] || single; // [R14]
	assign LNK.device_identity_inputs = single ? 3'h0 : strap_q[C_ID_LSB+:ID_W]; // [R11]
	assign LNK.input_width_select     = strap_q[C_IW];
	assign LNK.output_width_select    = strap_q[C_OW];
	assign LNK.bus_match_select       = strap_q[C_BM];
	assign LNK.output_enable_n        = ctrl_q[C_OE_N];
	assign LNK.almost_full_bus_strobe = stb_q; // [R2] [R3]
	assign LNK.write_queue_address    = single ? {3'h0, wa_q[QSEL_W-1:0]} : wa_q; // [R11]
	assign LNK.read_queue_address     = single ? {3'h0, ra_q[QSEL_W-1:0]} : ra_q; // [R11]
	assign LNK.write_select           = wsel_q;
	assign LNK.read_select            = rsel_q;
	assign LNK.full_bus_token_in      = !strap_q[C_POLLED] ? 1'b0 // [R7]
		: (single ? LNK.full_bus_token_out : CHAIN_TOKEN_IN); // [R7] [R8]
	assign CHAIN_TOKEN_OUT            = LNK.full_bus_token_out; // [R8]
endmodule

// file: mq_flag_pkg.sv
package mq_flag_pkg;
	// address bus split: device field above queue field
	localparam int QADDR_W  = 8;
	localparam int ID_W     = 3;
	localparam int QSEL_W   = 5;
	localparam int ID_LSB   = 5;
	localparam int QIDX_W   = 4;
	localparam int SECT_BIT = 3;
	localparam int NUM_Q    = 16;
	localparam int SECT_W   = 8;
	localparam int DATA_W   = 36;
	localparam int X18_W    = 18;
	localparam int X9_W     = 9;
	// timing counts in clock cycles
	localparam logic [3:0] PROG_CYCLES    = 4'hf;
	localparam logic [3:0] RST_LOW_CYCLES = 4'h4;
	// host register offsets and fields
	localparam int AXI_AW = 4;
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] SEL_OFS  = 4'h4;
	localparam logic [3:0] STAT_OFS = 4'h8;
	localparam int C_GO     = 0;
	localparam int C_POLLED = 1;
	localparam int C_MASTER = 2;
	localparam int C_ID_LSB = 4;
	localparam int C_IW     = 8;
	localparam int C_OW     = 9;
	localparam int C_BM     = 10;
	localparam int C_OE_N   = 11;
	localparam int C_SINGLE = 12;
	localparam int S_WSEL   = 8;
	localparam int S_RSEL   = 9;
	localparam int S_STROBE = 10;
	localparam int ST_BUSY  = 0;
	localparam int ST_PROG  = 1;
	localparam int ST_REFUS = 2;
	localparam int ST_SYNC  = 8;
	localparam int ST_FLAG  = 16;
	localparam logic [31:0] CTRL_RST = 32'h0000_0804;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_DEC = 2'h3;
	// enumerations
	typedef enum logic [1:0] {W36 = 2'b00, W18 = 2'b01, W9 = 2'b10} width_e;
	typedef enum logic [1:0] {P_WAIT = 2'b00, P_IDLE = 2'b01, P_SEC1 = 2'b10,
		P_SEC2 = 2'b11} poll_e;
	typedef enum logic [1:0] {C_IDLE = 2'b00, C_PRE = 2'b01, C_LOW = 2'b10} mrst_e;
endpackage

// file: flag_link_if.sv
`timescale 1ns/1ps
interface flag_link_if;
	import mq_flag_pkg::*;
	logic                master_reset_n;
	logic                flag_bus_mode;
	logic                master_select;
	logic [ID_W-1:0]     device_identity_inputs;
	logic                input_width_select;
	logic                output_width_select;
	logic                bus_match_select;
	logic                serial_program_done;
	logic                almost_full_bus_strobe;
	logic [QADDR_W-1:0]  write_queue_address;
	logic [QADDR_W-1:0]  read_queue_address;
	logic                write_select;
	logic                read_select;
	logic                output_enable_n;
	logic                full_bus_token_in;
	logic                full_bus_token_out;
	logic                almost_full_bus_sync;
	logic [SECT_W-1:0]   flag_out;
	logic                flag_oe;
	logic [DATA_W-1:0]   data_out;
	logic                data_oe;
	logic                output_valid_n_out;
	logic                output_valid_n_oe;
	logic [SECT_W-1:0]   almost_full_flag_bus;
	logic                output_valid_n;
	// undriven lines float high through pull-ups
	assign almost_full_flag_bus = flag_oe ? flag_out : 8'hff;
	assign output_valid_n       = output_valid_n_oe ? output_valid_n_out : 1'b1;
	modport dev (
		input  master_reset_n, flag_bus_mode, master_select, device_identity_inputs,
		input  input_width_select, output_width_select, bus_match_select,
		input  almost_full_bus_strobe, write_queue_address, read_queue_address,
		input  write_select, read_select, output_enable_n, full_bus_token_in,
		output serial_program_done, full_bus_token_out, almost_full_bus_sync,
		output flag_out, flag_oe, data_out, data_oe, output_valid_n_out, output_valid_n_oe
	);
	modport ctrl (
		output master_reset_n, flag_bus_mode, master_select, device_identity_inputs,
		output input_width_select, output_width_select, bus_match_select,
		output almost_full_bus_strobe, write_queue_address, read_queue_address,
		output write_select, read_select, output_enable_n, full_bus_token_in,
		input  serial_program_done, full_bus_token_out, almost_full_bus_sync,
		input  almost_full_flag_bus, output_valid_n
	);
endinterface

// file: queue_flag_end.sv
// Operation
// [R1] direct mode: strobe edge picks address sector
// [R2] host keeps strobe low when polled
// [R3] no strobe before programming done falls
// [R4] polled: sector 1, sector 2, repeat
// [R5] sync high on sector 1, low sector 2
// [R6] token pulse on sector 2; next loads
// [R7] single device token tie-low or self-loop
// [R8] chain tokens ring, last back first
// [R9] 8-bit address: 3 device, 5 queue
// [R10] identity latched at reset, compared on select
// [R11] single device: identity zero, upper bits low
// [R12] width selects give 9/18/36 port widths
// [R13] master strap at reset; slaves float outputs
// [R14] single device holds master select high
// [R15] reset high-low-high, then program
// [R16] master: output enable gates data bus
// [R17] slave data floats until read-selected
// [R18] valid flag two cycles after selection
// [R19] read-empty queue drives valid flag high
// [R20] flag mode strap: high polled, low direct
// [R21] polled sequencer starts after programming
// [R22] foreign identity: selection ignored, outputs float
`timescale 1ns/1ps
module queue_flag_end import mq_flag_pkg::*; (
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	input  wire logic [NUM_Q-1:0]  QUEUE_ALMOST_FULL,
	input  wire logic [NUM_Q-1:0]  QUEUE_EMPTY,
	input  wire logic [DATA_W-1:0] READ_DATA,
	output logic      [QIDX_W-1:0] WRITE_QUEUE,
	output logic      [QIDX_W-1:0] READ_QUEUE,
	output width_e                 IN_WIDTH,
	output width_e                 OUT_WIDTH,
	flag_link_if.dev               LNK
);
	logic              polled_q, polled_d;
	logic [ID_W-1:0]   id_q, id_d;
	logic              master_q, master_d;
	width_e            in_w_q, in_w_d, out_w_q, out_w_d;
	logic [3:0]        prog_cnt_q, prog_cnt_d;
	logic              prog_q, prog_d;
	poll_e             poll_q, poll_d;
	logic              sect2_q, sect2_d;
	logic              wown_q, wown_d;
	logic              rown_q, rown_d;
	logic [QIDX_W-1:0] wq_q, wq_d, rq_q, rq_d;
	logic [SECT_W-1:0] flag_q, flag_d;
	logic              foe_q, foe_d;
	logic              sync_q, sync_d;
	logic              tok_q, tok_d;
	logic              ov1_q, ov1_d, ov_q, ov_d;
	logic [DATA_W-1:0] dat1_q, dat1_d, dat_q, dat_d;
	logic [DATA_W-1:0] out_mask;
	logic              whit, rhit, sec2_now;

	// address decode: device field must match latched identity
	assign whit = (LNK.write_queue_address[QADDR_W-1:ID_LSB] == id_q) // [R9] [R10] [R22]
		&& !LNK.write_queue_address[QSEL_W-1];
	assign rhit = (LNK.read_queue_address[QADDR_W-1:ID_LSB] == id_q) // [R9] [R10] [R22]
		&& !LNK.read_queue_address[QSEL_W-1];

	// next-state logic for straps, programming, selection and flag bus sequencing
	always_comb begin
		polled_d   = polled_q;
		id_d       = id_q;
		master_d   = master_q;
		in_w_d     = in_w_q;
		out_w_d    = out_w_q;
		prog_cnt_d = prog_cnt_q;
		prog_d     = prog_q;
		poll_d     = poll_q;
		sect2_d    = sect2_q;
		wown_d     = wown_q;
		rown_d     = rown_q;
		wq_d       = wq_q;
		rq_d       = rq_q;
		if (!LNK.master_reset_n) begin
			// straps are caught every cycle the reset pin is low
			polled_d   = LNK.flag_bus_mode; // [R20]
			id_d       = LNK.device_identity_inputs; // [R10]
			master_d   = LNK.master_select; // [R13]
			rown_d     = LNK.master_select; // [R13]
			wown_d     = LNK.master_select; // [R13]
			prog_cnt_d = 4'h0;
			prog_d     = 1'b0; // [R15]
			poll_d     = P_WAIT;
			sect2_d    = 1'b0;
			// width pairs; one port always stays at full width
			in_w_d  = W36; // [R12]
			out_w_d = W36; // [R12]
			if (LNK.bus_match_select) begin
				case ({LNK.input_width_select, LNK.output_width_select})
					2'b00: in_w_d = W18;
					2'b01: in_w_d = W9;
					2'b10: out_w_d = W18;
					2'b11: out_w_d = W9;
					default: in_w_d = W36;
				endcase
			end
		end else begin
			// default programming takes a fixed number of cycles
			if (!prog_q) begin
				prog_cnt_d = prog_cnt_q + 4'h1;
				prog_d     = (prog_cnt_q == PROG_CYCLES);
			end
			if (LNK.write_select && whit) begin
				wq_d = LNK.write_queue_address[QIDX_W-1:0];
			end
			// read ownership passes to whichever device is addressed
			if (LNK.read_select) begin
				rown_d = rhit; // [R17] [R22]
				if (rhit) begin
					rq_d = LNK.read_queue_address[QIDX_W-1:0];
				end
			end
			// direct mode: strobe picks the sector, foreign id releases the bus
			if (!polled_q && prog_q && LNK.almost_full_bus_strobe) begin
				wown_d = whit; // [R1] [R22]
				if (whit) begin
					sect2_d = LNK.write_queue_address[SECT_BIT]; // [R1]
				end
			end
			// polled sequencer; token of the ring hands the bus on
			case (poll_q)
				P_WAIT: if (prog_q && polled_q) begin
					poll_d = master_q ? P_SEC1 : P_IDLE; // [R21]
				end
				P_IDLE: if (LNK.full_bus_token_in) begin
					poll_d = P_SEC1; // [R6]
				end
				P_SEC1: poll_d = P_SEC2; // [R4]
				P_SEC2: poll_d = LNK.full_bus_token_in ? P_SEC1 : P_IDLE; // [R4] [R6]
				default: poll_d = P_WAIT;
			endcase
		end
	end

	// flag bus contents follow the sector about to be shown
	always_comb begin
		sec2_now = polled_q ? (poll_d == P_SEC2) : sect2_d;
		flag_d   = sec2_now ? ~QUEUE_ALMOST_FULL[NUM_Q-1:SECT_W]
			: ~QUEUE_ALMOST_FULL[SECT_W-1:0]; // [R4] [R1]
		foe_d    = polled_q ? ((poll_d == P_SEC1) || (poll_d == P_SEC2))
			: (wown_d && prog_d); // [R22]
		sync_d   = polled_q && (poll_d == P_SEC1); // [R5]
		tok_d    = polled_q && (poll_d == P_SEC2); // [R6]
		if (!LNK.master_reset_n) begin
			foe_d  = 1'b0;
			sync_d = 1'b0;
			tok_d  = 1'b0;
		end
	end

	// read path: two stages so the valid flag lines up with data
	always_comb begin
		case (out_w_q)
			W18:     out_mask = {{(DATA_W-X18_W){1'b0}}, {X18_W{1'b1}}}; // [R12]
			W9:      out_mask = {{(DATA_W-X9_W){1'b0}}, {X9_W{1'b1}}}; // [R12]
			default: out_mask = {DATA_W{1'b1}};
		endcase
		ov1_d  = QUEUE_EMPTY[rq_q]; // [R18] [R19]
		ov_d   = ov1_q; // [R18]
		dat1_d = READ_DATA & out_mask;
		dat_d  = dat1_q;
	end

	// register stage; system reset leaves every device floating
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			polled_q   <= 1'b0;
			id_q       <= 3'h0;
			master_q   <= 1'b0;
			in_w_q     <= W36;
			out_w_q    <= W36;
			prog_cnt_q <= 4'h0;
			prog_q     <= 1'b0;
			poll_q     <= P_WAIT;
			sect2_q    <= 1'b0;
			wown_q     <= 1'b0;
			rown_q     <= 1'b0;
			wq_q       <= 4'h0;
			rq_q       <= 4'h0;
			flag_q     <= 8'hff;
			foe_q      <= 1'b0;
			sync_q     <= 1'b0;
			tok_q      <= 1'b0;
			ov1_q      <= 1'b1;
			ov_q       <= 1'b1;
			dat1_q     <= 36'h0;
			dat_q      <= 36'h0;
		end else begin
			polled_q   <= polled_d;
			id_q       <= id_d;
			master_q   <= master_d;
			in_w_q     <= in_w_d;
			out_w_q    <= out_w_d;
			prog_cnt_q <= prog_cnt_d;
			prog_q     <= prog_d;
			poll_q     <= poll_d;
			sect2_q    <= sect2_d;
			wown_q     <= wown_d;
			rown_q     <= rown_d;
			wq_q       <= wq_d;
			rq_q       <= rq_d;
			flag_q     <= flag_d;
			foe_q      <= foe_d;
			sync_q     <= sync_d;
			tok_q      <= tok_d;
			ov1_q      <= ov1_d;
			ov_q       <= ov_d;
			dat1_q     <= dat1_d;
			dat_q      <= dat_d;
		end
	end

	// output enable acts without the clock, gated by read ownership
	assign LNK.data_oe             = rown_q && !LNK.output_enable_n; // [R16] [R17]
	assign LNK.data_out            = dat_q;
	assign LNK.output_valid_n_out  = ov_q; // [R19]
	assign LNK.output_valid_n_oe   = rown_q; // [R13] [R22]
	assign LNK.flag_out            = flag_q;
	assign LNK.flag_oe             = foe_q;
	assign LNK.almost_full_bus_sync = sync_q;
	assign LNK.full_bus_token_out  = tok_q;
	assign LNK.serial_program_done = !prog_q; // [R3]
	assign WRITE_QUEUE             = wq_q;
	assign READ_QUEUE              = rq_q;
	assign IN_WIDTH                = in_w_q;
	assign OUT_WIDTH               = out_w_q;
endmodule

// file: mq_flag_checker.sv
`timescale 1ns/1ps
module mq_flag_checker (
	input wire logic       CLK,
	input wire logic       SYS_RST,
	input wire logic       master_reset_n,
	input wire logic       flag_bus_mode,
	input wire logic [2:0] device_identity_inputs,
	input wire logic       serial_program_done,
	input wire logic       almost_full_bus_strobe,
	input wire logic [7:0] write_queue_address,
	input wire logic [7:0] read_queue_address,
	input wire logic       read_select,
	input wire logic       output_enable_n,
	input wire logic       full_bus_token_in,
	input wire logic       full_bus_token_out,
	input wire logic       almost_full_bus_sync,
	input wire logic       flag_oe,
	input wire logic       data_oe,
	input wire logic       output_valid_n_oe
);
	logic wr_hit;
	logic rd_hit;

	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	// a selection counts only when the device field names this end
	assign wr_hit = write_queue_address[7:5] == device_identity_inputs && !write_queue_address[4];
	assign rd_hit = read_queue_address[7:5] == device_identity_inputs && !read_queue_address[4];

	a_sync_then_token: assert property
		(almost_full_bus_sync && master_reset_n |=> full_bus_token_out)
		else $error("token did not follow sector one");
	a_token_then_sync: assert property
		(full_bus_token_out && full_bus_token_in && master_reset_n |=> almost_full_bus_sync)
		else $error("returned token did not reload sector one");
	a_sync_token_apart: assert property
		(almost_full_bus_sync |-> !full_bus_token_out && flag_oe)
		else $error("sync and token overlap or bus undriven");
	a_quiet_in_reset: assert property
		(!master_reset_n |=> !almost_full_bus_sync && !full_bus_token_out)
		else $error("sequencer active during master reset");
	a_reset_pulse: assert property
		($fell(master_reset_n) |-> !master_reset_n [*5] ##1 master_reset_n)
		else $error("master reset low phase has wrong length");
	a_program_wait: assert property
		($rose(master_reset_n) |-> serial_program_done ##[14:18] !serial_program_done)
		else $error("programming done not reported in time");
	a_strobe_legal: assert property
		(almost_full_bus_strobe |-> !flag_bus_mode && !serial_program_done)
		else $error("strobe issued in polled mode or before programming");
	a_direct_pick: assert property (almost_full_bus_strobe && wr_hit |=> flag_oe)
		else $error("matching strobe did not drive flag bus");
	a_foreign_drop: assert property (almost_full_bus_strobe && !wr_hit |=> !flag_oe)
		else $error("foreign strobe left flag bus driven");
	a_read_own: assert property (read_select && rd_hit |=> output_valid_n_oe)
		else $error("read selection did not take the valid flag");
	a_oe_gate: assert property (data_oe |-> !output_enable_n)
		else $error("data bus driven with output enable high");

	c_polled_cycle: cover property (almost_full_bus_sync ##1 full_bus_token_out ##1 almost_full_bus_sync);
	c_direct_hit: cover property (almost_full_bus_strobe && wr_hit);
	c_read_drive: cover property (read_select && rd_hit ##2 data_oe);
endmodule

// file: test_multiqueue_expansion_flag_bus_ctrl.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s expected %h seen %h", n, (e), (g)); end end
module test_multiqueue_expansion_flag_bus_ctrl import mq_flag_pkg::*;;
	logic        CLK = 1'b0;
	logic        SYS_RST = 1'b1;
	logic [15:0] af = 16'h0;
	logic [15:0] emp = 16'h0;
	logic [3:0]  wq, rq, awaddr = 4'h0, araddr = 4'h0;
	width_e      iw_o, ow_o;
	logic [31:0] wdata = 32'h0, rdata_ax, rd;
	logic [1:0]  bresp, rresp, rs;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, tok_in = 1'b0, tok_out;
	int          bad_count = 0, check_count = 0, cyc = 0;
	logic [23:0] rows [5] = '{24'h40_a53c, 24'h48_a53c, 24'h00_ffff, 24'h4f_0f0f, 24'h43_8001};

	flag_link_if flag_link_if_i ();
	wire [7:0] bus = flag_link_if_i.almost_full_flag_bus;
	wire       sy  = flag_link_if_i.almost_full_bus_sync;
	wire       tk  = flag_link_if_i.full_bus_token_out;
	wire       ov  = flag_link_if_i.output_valid_n;
	wire       doe = flag_link_if_i.data_oe;

	// 20 MHz clock
	always #25 CLK = ~CLK;

	// read data tracks the selected queue so a stale selection shows up
	queue_flag_end queue_flag_end_i (.CLK(CLK), .SYS_RST(SYS_RST), .QUEUE_ALMOST_FULL(af),
		.QUEUE_EMPTY(emp), .READ_DATA({9{rq}}), .WRITE_QUEUE(wq), .READ_QUEUE(rq),
		.IN_WIDTH(iw_o), .OUT_WIDTH(ow_o), .LNK(flag_link_if_i.dev));
	queue_flag_host queue_flag_host_i (.CLK(CLK), .SYS_RST(SYS_RST), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata_ax), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CHAIN_TOKEN_IN(tok_in),
		.CHAIN_TOKEN_OUT(tok_out), .LNK(flag_link_if_i.ctrl));
	mq_flag_checker mq_flag_checker_i (.CLK(CLK), .SYS_RST(SYS_RST),
		.master_reset_n(flag_link_if_i.master_reset_n), .flag_bus_mode(flag_link_if_i.flag_bus_mode),
		.device_identity_inputs(flag_link_if_i.device_identity_inputs),
		.serial_program_done(flag_link_if_i.serial_program_done),
		.almost_full_bus_strobe(flag_link_if_i.almost_full_bus_strobe),
		.write_queue_address(flag_link_if_i.write_queue_address),
		.read_queue_address(flag_link_if_i.read_queue_address),
		.read_select(flag_link_if_i.read_select), .output_enable_n(flag_link_if_i.output_enable_n),
		.full_bus_token_in(flag_link_if_i.full_bus_token_in), .full_bus_token_out(tk),
		.almost_full_bus_sync(sy), .flag_oe(flag_link_if_i.flag_oe), .data_oe(doe),
		.output_valid_n_oe(flag_link_if_i.output_valid_n_oe));

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// register write: address and data offered together, each dropped once taken
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLK);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge CLK);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [3:0] a);
		@(posedge CLK);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge CLK);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata_ax;
		rs = rresp;
		rready <= 1'b0;
	endtask

	// start a master reset and wait until the device reports programmed
	task automatic go(input logic [31:0] c);
		axw(CTRL_OFS, c | 32'h1);
		do axr(STAT_OFS); while (rd[1:0] !== 2'b10);
	endtask

	// a hang counts as a mismatch
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		logic [7:0] a;
		logic [3:0] q;
		logic       hit;
		logic       bm;
		logic [1:0] iwow;
		width_e     ein;
		width_e     eout;
		repeat (12) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(negedge CLK);
		`CHK("flag bus", 8'hff, bus);
		`CHK("valid", 1'b1, ov);
		`CHK("prog done", 1'b1, flag_link_if_i.serial_program_done);
		axr(CTRL_OFS);
		`CHK("ctrl reset", CTRL_RST, rd);
		axr(4'hc);
		`CHK("rresp", RESP_DEC, rs);
		`CHK("rdata", 32'h0, rd);
		axw(4'hc, 32'h0);
		`CHK("bresp", RESP_DEC, rs);
		// every width combination; bus match off must ignore the two selects
		for (int i = 0; i < 5; i++) begin
			{bm, iwow} = (i == 0) ? 3'b011 : {1'b1, 2'(i - 1)};
			go(32'h1004 | {21'h0, bm, iwow[0], iwow[1], 8'h0});
			ein = !bm ? W36 : (iwow == 2'b00 ? W18 : (iwow == 2'b01 ? W9 : W36));
			eout = (!bm || !iwow[1]) ? W36 : (iwow[0] ? W9 : W18);
			`CHK("in width", ein, iw_o);
			`CHK("out width", eout, ow_o);
		end
		// slave with identity 2, direct flags, outputs enabled; first end of the chain
		tok_in <= 1'b0;
		go(32'h0000_0020);
		@(negedge CLK);
		`CHK("valid released", 1'b1, ov);
		`CHK("data released", 1'b0, doe);
		foreach (rows[i]) begin
			a = rows[i][23:16];
			q = a[3:0];
			hit = a[7:5] == 3'h2;
			af <= rows[i][15:0];
			emp <= rows[i][15:0] ^ 16'h0ff0;
			axw(SEL_OFS, 32'h700 | {24'h0, a});
			// valid and data must show the new queue two cycles after selection
			repeat (3) @(negedge CLK);
			`CHK("flag bus", hit ? (a[3] ? ~af[15:8] : ~af[7:0]) : 8'hff, bus);
			`CHK("valid", hit ? emp[q] : 1'b1, ov);
			`CHK("data oe", hit, doe);
			if (hit) begin
				`CHK("data", {9{q}}, flag_link_if_i.data_out);
				`CHK("write queue", q, wq);
				`CHK("read queue", q, rq);
			end
		end
		axw(CTRL_OFS, 32'h0000_0820);
		@(negedge CLK);
		`CHK("data oe off", 1'b0, doe);
		// single device polled: token loops inside, sectors alternate
		af <= 16'h3c96;
		go(32'h1806);
		do @(posedge CLK); while (!sy);
		for (int k = 0; k < 4; k++) begin
			@(negedge CLK);
			`CHK("sync", k[0], sy);
			`CHK("token", !k[0], tk);
			`CHK("sector", k[0] ? ~af[7:0] : ~af[15:8], bus);
		end
		axw(SEL_OFS, 32'h408);
		axr(STAT_OFS);
		`CHK("refused", 1'b1, rd[ST_REFUS]);
		axw(STAT_OFS, 32'h4);
		`CHK("bresp ok", RESP_OK, rs);
		axr(STAT_OFS);
		`CHK("refused clear", 1'b0, rd[ST_REFUS]);
		// chain master: without a returned token the bus goes quiet
		go(32'h0806);
		// the lone first token may pass while status is polled; just let it settle
		repeat (2) @(posedge CLK);
		repeat (3) begin
			@(negedge CLK);
			`CHK("idle sync", 1'b0, sy);
			`CHK("idle bus", 8'hff, bus);
		end
		@(posedge CLK);
		tok_in <= 1'b1;
		@(posedge CLK);
		tok_in <= 1'b0;
		@(negedge CLK);
		`CHK("resync", 1'b1, sy);
		`CHK("resector", ~af[7:0], bus);
		@(negedge CLK);
		`CHK("retoken", 1'b1, tk);
		`CHK("chain token", 1'b1, tok_out);
		complete_run();
	end
endmodule
